/* File: txl_launch_ctrl.v */
`timescale 1ns/1ps
`include "txl_map.vh"

// Summary of operation
// - each command bit clears itself when the activity it asks for starts.
// - bit 0 chooses, for the next frame only, whether the frame check is left out.
// - without suppression a crc-16 (x^16+x^12+x^5+1) over fetched octets is appended as the last two.
// - without suppression length minus two octets are fetched, with it the full length.
// - the suppression bit clears when the launch is seen and transmission starts.
// - bit 1 while idle starts a frame at once unless the deferred bit is also set.
// - the launch bit clears when the frame actually starts.
// - a scheduled send waits for its time, then clears bits 2 and 1 as the frame starts.
// - the low 9 bits of the 40-bit scheduled time are left out of the compare.
// - a scheduled frame starts one cycle before the upper bits of the time base equal the scheduled time's, and is stamped when they do.
module txl_launch_ctrl
#(
   parameter ADDR_W = 8,
   parameter LEN_W  = 7,
   parameter BUF_AW = 7
)
(
   input  wire              sys_clk,
   input  wire              rst_n,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire [39:0]       systemTimebase,
   output wire              bufRdEn,
   output wire [BUF_AW-1:0] bufRdAddr,
   input  wire [7:0]        bufRdData,
   output wire [7:0]        txData,
   output wire              txValid,
   output wire              txLast,
   input  wire              txReady,
   output wire              txStamp,
   output wire              txBusy
);

   localparam ST_IDLE  = 3'd0;
   localparam ST_DEFER = 3'd1;
   localparam ST_REQ   = 3'd2;
   localparam ST_LOAD  = 3'd3;
   localparam ST_SEND  = 3'd4;
   localparam ST_FCSL  = 3'd5;
   localparam ST_FCS1  = 3'd6;
   localparam ST_FCS2  = 3'd7;

   localparam [31:0] FCS_OCT = `TXL_FCS_OCTETS;
   localparam [31:0] LEN_RST = `TXL_FRAME_LEN_RESET;

   reg  [2:0]        state_ff;
   reg  [31:0]       systemControl_ff;
   reg  [39:0]       scheduledTime_ff;
   reg  [LEN_W-1:0]  frameLength_ff;
   reg               frameSuppress_ff;
   reg  [LEN_W-1:0]  remain_ff;
   reg  [BUF_AW-1:0] addr_ff;
   reg  [7:0]        outData_ff;
   reg               outValid_ff;
   reg               outLast_ff;
   reg               stamp_ff;
   reg  [31:0]       clrMask;
   reg  [31:0]       nxt_systemControl;
   reg  [31:0]       rdMux;
   reg               rdMiss;
   reg               wrMiss;
   reg  [LEN_W-1:0]  fetchLen;

   wire              wrEn;
   wire [ADDR_W-1:0] wrAddr;
   wire [31:0]       wrData;
   wire [3:0]        wrStrb;
   wire [ADDR_W-1:0] rdAddr;
   wire [31:0]       byteMask;
   wire [15:0]       crc;
   wire              launchCmd;
   wire              deferCmd;
   wire              suppressCmd;
   wire              timeMatch;
   wire [39:0]       nextTime;
   wire              startNow;
   wire              startDeferred;
   wire              frameStart;
   wire              crcEn;

   txl_axil_slave #(.ADDR_W(ADDR_W)) u_bus
   (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wrEn          (wrEn),
      .wrAddr        (wrAddr),
      .wrData        (wrData),
      .wrStrb        (wrStrb),
      .wrErr         (wrMiss),
      .rdAddr        (rdAddr),
      .rdData        (rdMux),
      .rdErr         (rdMiss)
   );

   txl_crc16 u_crc
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clr     (frameStart),
      .en      (crcEn),
      .din     (bufRdData),
      .crc     (crc)
   );

   assign byteMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};

   assign launchCmd   = systemControl_ff[`TXL_BIT_LAUNCH];
   assign deferCmd    = systemControl_ff[`TXL_BIT_DEFER];
   assign suppressCmd = systemControl_ff[`TXL_BIT_SUPPRESS];

   // upper bits only; one cycle early so the stamp lands on the scheduled time
   assign nextTime  = systemTimebase + 40'h00_0000_0001;
   assign timeMatch = nextTime[39:`TXL_SCHED_IGNORE] == scheduledTime_ff[39:`TXL_SCHED_IGNORE];

   // a launch seen outside idle simply waits in the register
   assign startNow      = (state_ff == ST_IDLE) && launchCmd && !deferCmd;
   assign startDeferred = (state_ff == ST_DEFER) && timeMatch;
   assign frameStart    = startNow || startDeferred;
   assign crcEn         = (state_ff == ST_LOAD) && !frameSuppress_ff;

   assign bufRdEn   = (state_ff == ST_REQ);
   assign bufRdAddr = addr_ff;
   assign txData    = outData_ff;
   assign txValid   = outValid_ff;
   assign txLast    = outLast_ff;
   assign txStamp   = stamp_ff;
   assign txBusy    = (state_ff != ST_IDLE);

   // octets taken from the buffer for this launch
   always @*
   begin
      if (suppressCmd)
      begin
         fetchLen = frameLength_ff;
      end
      else if (frameLength_ff > `TXL_FCS_OCTETS)
      begin
         fetchLen = frameLength_ff - FCS_OCT[LEN_W-1:0];
      end
      else
      begin
         fetchLen = {LEN_W{1'b0}};
      end
   end

   // hardware clears, a same-cycle write wins
   always @*
   begin
      clrMask = 32'h0000_0000;
      if (frameStart)
      begin
         clrMask[`TXL_BIT_LAUNCH]   = 1'b1;
         clrMask[`TXL_BIT_SUPPRESS] = 1'b1;
         clrMask[`TXL_BIT_DEFER]    = 1'b1;
      end
      nxt_systemControl = systemControl_ff & ~clrMask;
      if (wrEn && (wrAddr == `TXL_ADDR_SYSTEM_CONTROL))
      begin
         nxt_systemControl = (nxt_systemControl & ~byteMask) | (wrData & byteMask & `TXL_CTRL_WR_MASK);
      end
   end

   always @*
   begin
      wrMiss = 1'b0;
      case (wrAddr)
         `TXL_ADDR_SYSTEM_CONTROL,
         `TXL_ADDR_SCHED_LO,
         `TXL_ADDR_SCHED_HI,
         `TXL_ADDR_FRAME_LEN : wrMiss = 1'b0;
         default             : wrMiss = 1'b1;
      endcase
   end

   always @*
   begin
      rdMux  = 32'h0000_0000;
      rdMiss = 1'b0;
      case (rdAddr)
         `TXL_ADDR_SYSTEM_CONTROL  : rdMux = systemControl_ff;
         `TXL_ADDR_SCHED_LO  : rdMux = scheduledTime_ff[31:0];
         `TXL_ADDR_SCHED_HI  : rdMux = {24'h00_0000, scheduledTime_ff[39:32]};
         `TXL_ADDR_FRAME_LEN : rdMux = {{(32-LEN_W){1'b0}}, frameLength_ff};
         `TXL_ADDR_STATUS    : rdMux = {27'h000_0000, frameSuppress_ff, txBusy, state_ff};
         default             : rdMiss = 1'b1;
      endcase
   end

   // register writes
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         systemControl_ff <= `TXL_CTRL_RESET;
         scheduledTime_ff <= `TXL_SCHED_RESET;
         frameLength_ff   <= LEN_RST[LEN_W-1:0];
      end
      else
      begin
         systemControl_ff <= nxt_systemControl;
         if (wrEn && (wrAddr == `TXL_ADDR_SCHED_LO))
         begin
            scheduledTime_ff[31:0] <= (scheduledTime_ff[31:0] & ~byteMask) | (wrData & byteMask);
         end
         if (wrEn && (wrAddr == `TXL_ADDR_SCHED_HI) && wrStrb[0])
         begin
            scheduledTime_ff[39:32] <= wrData[7:0];
         end
         if (wrEn && (wrAddr == `TXL_ADDR_FRAME_LEN) && wrStrb[0])
         begin
            frameLength_ff <= wrData[LEN_W-1:0];
         end
      end
   end

   // frame sequencer
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff         <= ST_IDLE;
         frameSuppress_ff <= 1'b0;
         remain_ff        <= {LEN_W{1'b0}};
         addr_ff          <= {BUF_AW{1'b0}};
         outData_ff       <= 8'h00;
         outValid_ff      <= 1'b0;
         outLast_ff       <= 1'b0;
         stamp_ff         <= 1'b0;
      end
      else
      begin
         stamp_ff <= frameStart;
         if (frameStart)
         begin
            frameSuppress_ff <= suppressCmd;
            remain_ff        <= fetchLen;
            addr_ff          <= {BUF_AW{1'b0}};
            if (fetchLen != {LEN_W{1'b0}})
            begin
               state_ff <= ST_REQ;
            end
            else if (!suppressCmd)
            begin
               state_ff <= ST_FCSL;
            end
            else
            begin
               state_ff <= ST_IDLE;
            end
         end
         else
         begin
            case (state_ff)
               ST_IDLE :
               begin
                  if (launchCmd && deferCmd)
                  begin
                     state_ff <= ST_DEFER;
                  end
               end
               ST_DEFER :
               begin
                  state_ff <= ST_DEFER;
               end
               ST_REQ :
               begin
                  state_ff <= ST_LOAD;
               end
               ST_LOAD :
               begin
                  outData_ff  <= bufRdData;
                  outValid_ff <= 1'b1;
                  outLast_ff  <= frameSuppress_ff && (remain_ff == {{(LEN_W-1){1'b0}}, 1'b1});
                  remain_ff   <= remain_ff - {{(LEN_W-1){1'b0}}, 1'b1};
                  addr_ff     <= addr_ff + {{(BUF_AW-1){1'b0}}, 1'b1};
                  state_ff    <= ST_SEND;
               end
               ST_SEND :
               begin
                  if (txReady)
                  begin
                     outValid_ff <= 1'b0;
                     outLast_ff  <= 1'b0;
                     if (remain_ff != {LEN_W{1'b0}})
                     begin
                        state_ff <= ST_REQ;
                     end
                     else if (!frameSuppress_ff)
                     begin
                        state_ff <= ST_FCSL;
                     end
                     else
                     begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_FCSL :
               begin
                  outData_ff  <= crc[7:0];
                  outValid_ff <= 1'b1;
                  outLast_ff  <= 1'b0;
                  state_ff    <= ST_FCS1;
               end
               ST_FCS1 :
               begin
                  if (txReady)
                  begin
                     outData_ff <= crc[15:8];
                     outLast_ff <= 1'b1;
                     state_ff   <= ST_FCS2;
                  end
               end
               ST_FCS2 :
               begin
                  if (txReady)
                  begin
                     outValid_ff <= 1'b0;
                     outLast_ff  <= 1'b0;
                     state_ff    <= ST_IDLE;
                  end
               end
               default :
               begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

/* File: txl_map.vh */
`ifndef TXL_MAP_VH
`define TXL_MAP_VH

// register indices, byte address is index times four
`define TXL_SYSTEM_CONTROL_IDX       8'h0D
`define TXL_SCHED_LO_IDX       8'h0A
`define TXL_ADDR_SYSTEM_CONTROL      (`TXL_SYSTEM_CONTROL_IDX << 2)
`define TXL_ADDR_SCHED_LO      (`TXL_SCHED_LO_IDX << 2)
`define TXL_ADDR_SCHED_HI      8'h40
`define TXL_ADDR_FRAME_LEN     8'h44
`define TXL_ADDR_STATUS        8'h48

// system control fields
`define TXL_BIT_SUPPRESS       0
`define TXL_BIT_LAUNCH         1
`define TXL_BIT_DEFER          2
`define TXL_CTRL_WR_MASK       32'h0000_0007
`define TXL_CTRL_RESET         32'h0000_0000
`define TXL_SCHED_RESET        40'h00_0000_0000
`define TXL_FRAME_LEN_RESET    32'h0000_0000

// low bits of the scheduled time left out of the compare
`define TXL_SCHED_IGNORE       9

// frame check
`define TXL_FCS_OCTETS         2
`define TXL_CRC_POLY_REFL      16'h8408
`define TXL_CRC_INIT           16'h0000

// bus responses
`define TXL_RESP_OKAY          2'b00
`define TXL_RESP_SLVERR        2'b10

`endif

/* File: txl_crc16.v */
`timescale 1ns/1ps
`include "txl_map.vh"

module txl_crc16
(
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        clr,
   input  wire        en,
   input  wire [7:0]  din,
   output wire [15:0] crc
);

   reg  [15:0] crc_ff;
   reg  [15:0] nxt_crc;
   reg         fb;
   integer     i;

   // lsb-first crc, x^16+x^12+x^5+1
   always @*
   begin
      nxt_crc = crc_ff;
      fb      = 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
         fb      = nxt_crc[0] ^ din[i];
         nxt_crc = {1'b0, nxt_crc[15:1]};
         if (fb)
         begin
            nxt_crc = nxt_crc ^ `TXL_CRC_POLY_REFL;
         end
      end
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         crc_ff <= `TXL_CRC_INIT;
      end
      else if (clr)
      begin
         crc_ff <= `TXL_CRC_INIT;
      end
      else if (en)
      begin
         crc_ff <= nxt_crc;
      end
   end

   assign crc = crc_ff;

endmodule

/* File: txl_axil_slave.v */
`timescale 1ns/1ps
`include "txl_map.vh"

module txl_axil_slave
#(
   parameter ADDR_W = 8
)
(
   input  wire              sys_clk,
   input  wire              rst_n,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   output wire              wrEn,
   output wire [ADDR_W-1:0] wrAddr,
   output wire [31:0]       wrData,
   output wire [3:0]        wrStrb,
   input  wire              wrErr,
   output wire [ADDR_W-1:0] rdAddr,
   input  wire [31:0]       rdData,
   input  wire              rdErr
);

   reg              awHeld_ff;
   reg [ADDR_W-1:0] awAddr_ff;
   reg              wHeld_ff;
   reg [31:0]       wData_ff;
   reg [3:0]        wStrb_ff;
   reg              bValid_ff;
   reg [1:0]        bResp_ff;
   reg              rValid_ff;
   reg [31:0]       rData_ff;
   reg [1:0]        rResp_ff;

   assign s_axi_awready = !awHeld_ff && !bValid_ff;
   assign s_axi_wready  = !wHeld_ff && !bValid_ff;
   assign s_axi_arready = !rValid_ff;
   assign wrEn          = awHeld_ff && wHeld_ff && !bValid_ff;
   assign wrAddr        = awAddr_ff;
   assign wrData        = wData_ff;
   assign wrStrb        = wStrb_ff;
   assign rdAddr        = s_axi_araddr;
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= {ADDR_W{1'b0}};
         wHeld_ff  <= 1'b0;
         wData_ff  <= 32'h0000_0000;
         wStrb_ff  <= 4'h0;
         bValid_ff <= 1'b0;
         bResp_ff  <= `TXL_RESP_OKAY;
         rValid_ff <= 1'b0;
         rData_ff  <= 32'h0000_0000;
         rResp_ff  <= `TXL_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (wrEn)
         begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bValid_ff <= 1'b1;
            bResp_ff  <= wrErr ? `TXL_RESP_SLVERR : `TXL_RESP_OKAY;
         end
         else if (bValid_ff && s_axi_bready)
         begin
            bValid_ff <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            rValid_ff <= 1'b1;
            rData_ff  <= rdData;
            rResp_ff  <= rdErr ? `TXL_RESP_SLVERR : `TXL_RESP_OKAY;
         end
         else if (rValid_ff && s_axi_rready)
         begin
            rValid_ff <= 1'b0;
         end
      end
   end

endmodule

/* File: txl_launch_ctrl_props.sv */
`timescale 1ns/1ps
`include "txl_map.vh"
module txl_launch_props
#(
   parameter ADDR_W = 8,
   parameter BUF_AW = 7
)
(
   input wire              sys_clk,
   input wire              rst_n,
   input wire [1:0]        s_axi_bresp,
   input wire              s_axi_bvalid,
   input wire              s_axi_bready,
   input wire              s_axi_arvalid,
   input wire              s_axi_arready,
   input wire [31:0]       s_axi_rdata,
   input wire              s_axi_rvalid,
   input wire              s_axi_rready,
   input wire              bufRdEn,
   input wire [BUF_AW-1:0] bufRdAddr,
   input wire [7:0]        txData,
   input wire              txValid,
   input wire              txLast,
   input wire              txReady,
   input wire              txStamp,
   input wire              txBusy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_stamp_frame_start: assert property (txStamp |-> bufRdAddr == 0 && !txValid)
      else $error("stamp not at start of frame");
   a_stamp_one_cycle: assert property (txStamp |=> !txStamp)
      else $error("stamp longer than one cycle");
   a_fetch_to_send: assert property (bufRdEn |-> ##2 txValid)
      else $error("fetched octet not offered two cycles later");
   a_fetch_spacing: assert property (bufRdEn |=> !bufRdEn ##1 !bufRdEn)
      else $error("fetches closer than three cycles");
   a_octet_holds: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
      else $error("octet changed before it was taken");
   a_stream_busy: assert property (txValid |-> txBusy && !bufRdEn)
      else $error("octet offered while idle or during fetch");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   c_frame_start: cover property (txStamp);
   c_frame_end: cover property (txValid && txReady && txLast);
   c_bus_error: cover property (s_axi_bvalid && s_axi_bresp == `TXL_RESP_SLVERR);
endmodule
bind txl_launch_ctrl txl_launch_props #(.ADDR_W(ADDR_W), .BUF_AW(BUF_AW)) i_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bufRdEn(bufRdEn),
   .bufRdAddr(bufRdAddr), .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady),
   .txStamp(txStamp), .txBusy(txBusy));

/* File: tb.sv */
`timescale 1ns/1ps
`include "txl_map.vh"
module tb;
   logic        sys_clk = 1'h0, rst_n = 1'h0, txReady = 1'h0, rdPend = 1'h0, sup;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, bufRdData = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rdv, seedv;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  rsp;
   logic [39:0] systemTimebase = 40'h0, tgt, diff;
   logic [6:0]  rdAddrQ = 7'h0;
   logic [7:0]  mem [0:127];
   logic [8:0]  rxq [$];
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire         bufRdEn, txValid, txLast, txStamp, txBusy;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [6:0]  bufRdAddr;
   wire  [7:0]  txData;
   int          n_errors = 0, checks_done = 0, cycles = 0, len, n;
   int          lens [6] = '{2, 1, 127, 127, 0, 0};

   txl_launch_ctrl #(.ADDR_W(8), .LEN_W(7), .BUF_AW(7)) i_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .systemTimebase(systemTimebase), .bufRdEn(bufRdEn), .bufRdAddr(bufRdAddr), .bufRdData(bufRdData),
      .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady), .txStamp(txStamp),
      .txBusy(txBusy));

   initial forever #20 sys_clk = ~sys_clk;

   // buffer answers the cycle after a fetch, else a toggling pattern; sink stalls at random
   always @(posedge sys_clk)
   begin
      systemTimebase <= systemTimebase + 40'h1;
      txReady <= ($urandom % 4) != 0;
      bufRdData <= rdPend ? mem[rdAddrQ] : ~bufRdData;
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         n_errors++;
         close_out();
      end
   end

   always @(negedge sys_clk)
   begin
      rdPend <= bufRdEn;
      rdAddrQ <= bufRdAddr;
      if (txValid && txReady)
         rxq.push_back({txLast, txData});
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic tA, tW, tB, done;
      int k;
      done = 1'h0;
      k = 0;
      rsp = 2'h3;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!done && k < 100)
      begin
         @(negedge sys_clk);
         k++;
         tA = s_axi_awvalid && s_axi_awready;
         tW = s_axi_wvalid && s_axi_wready;
         tB = s_axi_bvalid && s_axi_bready;
         if (tB)
            rsp = s_axi_bresp;
         @(posedge sys_clk);
         if (tA)
            s_axi_awvalid <= 1'h0;
         if (tW)
            s_axi_wvalid <= 1'h0;
         if (tB)
            s_axi_bready <= 1'h0;
         done = tB;
      end
      if (!done)
         n_errors++;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      logic tA, tR, done;
      int k;
      done = 1'h0;
      k = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!done && k < 100)
      begin
         @(negedge sys_clk);
         k++;
         tA = s_axi_arvalid && s_axi_arready;
         tR = s_axi_rvalid && s_axi_rready;
         if (tR)
         begin
            rdv = s_axi_rdata;
            rsp = s_axi_rresp;
         end
         @(posedge sys_clk);
         if (tA)
            s_axi_arvalid <= 1'h0;
         if (tR)
            s_axi_rready <= 1'h0;
         done = tR;
      end
      if (!done)
         n_errors++;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      axi_rd(a);
      chk(rdv, exp);
      chk({30'h0, rsp}, {30'h0, er});
   endtask

   function automatic logic [15:0] crc_of(input int cnt);
      logic [15:0] c;
      logic        fb;
      c = `TXL_CRC_INIT;
      for (int i = 0; i < cnt; i++)
         for (int b = 0; b < 8; b++)
         begin
            fb = c[0] ^ mem[i][b];
            c = c >> 1;
            if (fb)
               c = c ^ `TXL_CRC_POLY_REFL;
         end
      return c;
   endfunction

   task automatic check_frame(input int fl, input logic sp, input int cnt);
      logic [15:0] c;
      logic [7:0]  e;
      int          j, k;
      c = crc_of(fl - 2);
      k = 0;
      while ((rxq.size() < fl * cnt || txBusy !== 1'h0) && k < 3000)
      begin
         @(negedge sys_clk);
         k++;
      end
      chk(32'(rxq.size()), 32'(fl * cnt));
      for (int i = 0; i < rxq.size(); i++)
      begin
         j = i % fl;
         e = (sp || j < fl - 2) ? mem[j] : (j == fl - 2 ? c[7:0] : c[15:8]);
         chk({23'h0, rxq[i]}, {23'h0, j == fl - 1, e});
      end
      rxq.delete();
   endtask

   initial
   begin
      seedv = $urandom(32'hD4E6);
      for (int i = 0; i < 128; i++)
         mem[i] = 8'($urandom);
      systemTimebase = {8'h12, 32'($urandom)};
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'h1;
      rd_chk(`TXL_ADDR_SYSTEM_CONTROL, `TXL_CTRL_RESET, `TXL_RESP_OKAY);
      rd_chk(`TXL_ADDR_FRAME_LEN, `TXL_FRAME_LEN_RESET, `TXL_RESP_OKAY);
      rd_chk(8'h3C, 32'h0, `TXL_RESP_SLVERR);
      axi_wr(8'h3C, 32'hFFFFFFFF);
      chk({30'h0, rsp}, {30'h0, `TXL_RESP_SLVERR});
      axi_wr(`TXL_ADDR_SYSTEM_CONTROL, 32'h0);
      rd_chk(`TXL_ADDR_SYSTEM_CONTROL, 32'h0, `TXL_RESP_OKAY);
      $display("test register map done");
      for (int i = 0; i < 6; i++)
      begin
         sup = i[0];
         len = (i < 4) ? lens[i] : 3 + $urandom % 60;
         axi_wr(`TXL_ADDR_FRAME_LEN, 32'(len));
         axi_wr(`TXL_ADDR_SYSTEM_CONTROL, {30'h0, 1'h1, sup});
         check_frame(len, sup, 1);
         rd_chk(`TXL_ADDR_SYSTEM_CONTROL, 32'h0, `TXL_RESP_OKAY);
         $display("test frame length %0d suppress %0d done", len, sup);
      end
      axi_wr(`TXL_ADDR_FRAME_LEN, 32'h14);
      axi_wr(`TXL_ADDR_SYSTEM_CONTROL, 32'h3);
      n = 0;
      while (txBusy !== 1'h1 && n < 100)
      begin
         @(negedge sys_clk);
         n++;
      end
      axi_wr(`TXL_ADDR_SYSTEM_CONTROL, 32'h3);
      check_frame(20, 1'h1, 2);
      $display("test launch while busy done");
      tgt = systemTimebase + 40'h800;
      tgt[8:0] = 9'($urandom);
      axi_wr(`TXL_ADDR_SCHED_LO, tgt[31:0]);
      axi_wr(`TXL_ADDR_SCHED_HI, {24'h0, tgt[39:32]});
      axi_wr(`TXL_ADDR_FRAME_LEN, 32'h6);
      axi_wr(`TXL_ADDR_SYSTEM_CONTROL, 32'h6);
      rd_chk(`TXL_ADDR_SYSTEM_CONTROL, 32'h6, `TXL_RESP_OKAY);
      axi_rd(`TXL_ADDR_STATUS);
      chk({31'h0, rdv[3]}, 32'h1);
      n = 0;
      while (txStamp !== 1'h1 && n < 5000)
      begin
         @(negedge sys_clk);
         n++;
      end
      diff = systemTimebase - {tgt[39:9], 9'h000};
      chk(diff[31:0], 32'h0);
      check_frame(6, 1'h0, 1);
      rd_chk(`TXL_ADDR_SYSTEM_CONTROL, 32'h0, `TXL_RESP_OKAY);
      $display("test deferred send done");
      close_out();
   end
endmodule
